// [shared/cmrs_pkg.sv]
package cmrs_pkg;
    // Register byte offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] PLLCFG_OFS = 8'h04;
    localparam logic [7:0] STAT_OFS = 8'h08;
    localparam logic [7:0] SRC_OFS = 8'h0C;
    // Control fields
    localparam int CTRL_PLL_CLOCK_SELECT_BIT = 0;
    localparam int CTRL_OSCEN_BIT = 1;
    localparam int CTRL_OSC_MONITOR_RESET_ENABLE_BIT = 2;
    localparam int CTRL_LOCK_IRQ_ENABLE_BIT = 3;
    localparam int CTRL_OSC_STATUS_IRQ_ENABLE_BIT = 4;
    localparam int CTRL_AUXSTOP_BIT = 5;
    localparam int CTRL_WDSRC_LSB = 6;
    localparam int CTRL_WDPER_LSB = 8;
    localparam int CTRL_STOP_BIT = 11;
    localparam int CTRL_FSTOP_BIT = 12;
    // PLL config fields
    localparam int CFG_POST_LSB = 0;
    localparam int CFG_LOOP_LSB = 8;
    localparam int CFG_REF_LSB = 16;
    // Status flags
    localparam int STAT_LOCK_BIT = 0;
    localparam int STAT_OSCUP_BIT = 1;
    localparam int STAT_LOCKCHG_BIT = 2;
    localparam int STAT_OSCCHG_BIT = 3;
    // Reset values
    localparam logic [4:0] POST_DIV_RST = 5'h03;
    localparam logic [5:0] LOOP_MUL_RST = 6'h18;
    localparam logic [3:0] REF_DIV_RST = 4'h0;
    localparam logic [31:0] CTRL_RST = 32'h0000_0001;
    // Reset sequence lengths in PLL output cycles
    localparam int PIN_LOW_CYCLES = 512;
    localparam int SEQ_CYCLES = 768;
    // Reset source encodings
    localparam logic [2:0] SRC_POR = 3'h1;
    localparam logic [2:0] SRC_LVR = 3'h2;
    localparam logic [2:0] SRC_PIN = 3'h3;
    localparam logic [2:0] SRC_PLLMON = 3'h4;
    localparam logic [2:0] SRC_OSCMON = 3'h5;
    localparam logic [2:0] SRC_WDOG = 3'h6;
    // Clock configuration modes
    typedef enum logic [1:0] {
        CMRS_INT_REF_TYPE_PEI,
        CMRS_EXT_REF_TYPE_PEE,
        CMRS_BYPASS_TYPE_PBE
    } cmrs_mode_type;
endpackage

// [rtl/cmrs_sequencer.sv]
// The placing of the registers and the AHB-Lite interface to the registers were decided locally.
`timescale 1ns/100ps
module cmrs_sequencer #(
    parameter int PIN_LOW = cmrs_pkg::PIN_LOW_CYCLES,
    parameter int SEQ_LEN = cmrs_pkg::SEQ_CYCLES
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic pll_tick,
    input wire logic pll_locked,
    input wire logic osc_good,
    input wire logic osc_freq_ok,
    input wire logic pll_freq_ok,
    input wire logic por_event,
    input wire logic lvr_event,
    input wire logic wdog_event,
    input wire logic reset_pin_in,
    output logic reset_pin_out,
    output logic reset_pin_oe,
    output logic sys_reset_n,
    output logic osc_enable,
    output logic pll_enable,
    output logic pll_clock_select,
    output logic use_osc_ref,
    output logic pll_at_reset_freq,
    output logic force_div4,
    output logic [4:0] post_divider,
    output logic [5:0] loop_multiplier,
    output logic [3:0] ref_divider,
    output logic [1:0] wdog_clock_sel,
    output logic lock_irq_enable,
    output logic osc_status_irq_enable,
    output logic aux_clock_stop_disable,
    output logic [1:0] clock_mode
);
    logic [31:0] ctrl_q;
    logic [4:0] post_q;
    logic [5:0] loop_q;
    logic [3:0] refd_q;
    logic lock_q, oscup_q, lockchg_q, oscchg_q;
    logic [2:0] src_q;
    logic [9:0] cnt_q;
    logic seq_q;
    logic wr_pend_q, rd_pend_q;
    logic [7:0] addr_q;
    logic full_stop, stop, osc_en, osc_monitor_reset_enable, mon_osc, mon_pll, trig, wr_en;
    logic [2:0] trig_src;
    cmrs_pkg::cmrs_mode_type mode;

    function automatic logic [31:0] field_upd(input logic [31:0] old_v, input logic [31:0] new_v,
            input logic [31:0] mask);
        field_upd = (old_v & ~mask) | (new_v & mask);
    endfunction

    assign full_stop = ctrl_q[cmrs_pkg::CTRL_FSTOP_BIT];
    assign stop = ctrl_q[cmrs_pkg::CTRL_STOP_BIT] | full_stop;
    assign osc_en = ctrl_q[cmrs_pkg::CTRL_OSCEN_BIT] & ~full_stop;
    assign osc_monitor_reset_enable = ctrl_q[cmrs_pkg::CTRL_OSC_MONITOR_RESET_ENABLE_BIT];
    assign pll_enable = ~full_stop;

    // Bus slave: one-cycle address phase, zero-wait data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            addr_q <= 8'h00;
        end else if (hready) begin
            wr_pend_q <= hsel & htrans[1] & hwrite;
            rd_pend_q <= hsel & htrans[1] & ~hwrite;
            addr_q <= haddr[7:0];
        end
    end
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign wr_en = wr_pend_q;

    // Control register, with hardware select override
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_q <= cmrs_pkg::CTRL_RST;
        end else begin
            if (wr_en && addr_q == cmrs_pkg::CTRL_OFS) begin
                // Monitor enable frozen while oscillator runs
                ctrl_q <= field_upd(hwdata, ctrl_q,
                    osc_en ? (32'h1 << cmrs_pkg::CTRL_OSC_MONITOR_RESET_ENABLE_BIT) : 32'h0) & 32'h0000_1FFF;
            end
            if (oscup_q && !(osc_good && lock_q && pll_locked && osc_en)) begin
                ctrl_q[cmrs_pkg::CTRL_PLL_CLOCK_SELECT_BIT] <= 1'b1;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            post_q <= cmrs_pkg::POST_DIV_RST;
            loop_q <= cmrs_pkg::LOOP_MUL_RST;
            refd_q <= cmrs_pkg::REF_DIV_RST;
        end else if (wr_en && addr_q == cmrs_pkg::PLLCFG_OFS) begin
            post_q <= hwdata[cmrs_pkg::CFG_POST_LSB +: 5];
            loop_q <= hwdata[cmrs_pkg::CFG_LOOP_LSB +: 6];
            refd_q <= hwdata[cmrs_pkg::CFG_REF_LSB +: 4];
        end
    end

    // Status flags; change flags set wins over clear-by-one
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lock_q <= 1'b0;
            oscup_q <= 1'b0;
            lockchg_q <= 1'b0;
            oscchg_q <= 1'b0;
        end else begin
            logic nlock, nosc;
            nlock = pll_locked & pll_enable;
            nosc = osc_good & osc_en & nlock;
            lock_q <= nlock;
            oscup_q <= nosc;
            if (nlock != lock_q) begin
                lockchg_q <= 1'b1;
            end else if (wr_en && addr_q == cmrs_pkg::STAT_OFS
                    && hwdata[cmrs_pkg::STAT_LOCKCHG_BIT]) begin
                lockchg_q <= 1'b0;
            end
            if (nosc != oscup_q) begin
                oscchg_q <= 1'b1;
            end else if (wr_en && addr_q == cmrs_pkg::STAT_OFS
                    && hwdata[cmrs_pkg::STAT_OSCCHG_BIT]) begin
                oscchg_q <= 1'b0;
            end
        end
    end

    assign mon_osc = osc_en & osc_monitor_reset_enable & ~(osc_good & osc_freq_ok);
    // PLL monitor, ungated except full stop
    assign mon_pll = pll_enable & ~pll_freq_ok;

    always_comb begin
        trig_src = 3'h0;
        if (por_event) begin
            trig_src = cmrs_pkg::SRC_POR;
        end else if (lvr_event) begin
            trig_src = cmrs_pkg::SRC_LVR;
        end else if (!reset_pin_in && !reset_pin_oe) begin
            trig_src = cmrs_pkg::SRC_PIN;
        end else if (mon_pll) begin
            trig_src = cmrs_pkg::SRC_PLLMON;
        end else if (mon_osc) begin
            trig_src = cmrs_pkg::SRC_OSCMON;
        end else if (wdog_event && ctrl_q[cmrs_pkg::CTRL_WDPER_LSB +: 3] != 3'h0) begin
            trig_src = cmrs_pkg::SRC_WDOG;
        end
    end
    assign trig = (trig_src != 3'h0) && !seq_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            seq_q <= 1'b0;
            cnt_q <= 10'h000;
            src_q <= 3'h0;
        end else if (trig) begin
            seq_q <= 1'b1;
            cnt_q <= 10'h000;
            src_q <= trig_src;
        end else if (seq_q) begin
            if (cnt_q < 10'(SEQ_LEN)) begin
                cnt_q <= cnt_q + {9'h000, pll_tick};
            end else if (reset_pin_in) begin
                seq_q <= 1'b0;
            end
        end
    end

    assign reset_pin_out = 1'b0;
    // Drive pin low first 512 cycles
    assign reset_pin_oe = seq_q && cnt_q < 10'(PIN_LOW);
    assign sys_reset_n = ~seq_q;
    assign pll_at_reset_freq = seq_q;
    assign force_div4 = ~lock_q | (osc_en & ~oscup_q);
    assign post_divider = post_q;
    assign loop_multiplier = loop_q;
    assign ref_divider = refd_q;
    assign pll_clock_select = ctrl_q[cmrs_pkg::CTRL_PLL_CLOCK_SELECT_BIT];
    assign use_osc_ref = osc_en;
    assign osc_enable = osc_en;
    // Watchdog source, oscillator only with it on
    assign wdog_clock_sel = (!osc_en && ctrl_q[cmrs_pkg::CTRL_WDSRC_LSB +: 2] == 2'h2) ? 2'h0
        : ctrl_q[cmrs_pkg::CTRL_WDSRC_LSB +: 2];
    assign lock_irq_enable = ctrl_q[cmrs_pkg::CTRL_LOCK_IRQ_ENABLE_BIT];
    assign osc_status_irq_enable = ctrl_q[cmrs_pkg::CTRL_OSC_STATUS_IRQ_ENABLE_BIT];
    assign aux_clock_stop_disable = ctrl_q[cmrs_pkg::CTRL_AUXSTOP_BIT] & stop;

    always_comb begin
        if (!osc_en) begin
            mode = cmrs_pkg::CMRS_INT_REF_TYPE_PEI;
        end else if (pll_clock_select) begin
            mode = cmrs_pkg::CMRS_EXT_REF_TYPE_PEE;
        end else begin
            mode = cmrs_pkg::CMRS_BYPASS_TYPE_PBE;
        end
    end
    assign clock_mode = mode;

    // Read data
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (hready && hsel && htrans[1] && !hwrite) begin
            case (haddr[7:0])
                cmrs_pkg::CTRL_OFS: hrdata <= ctrl_q;
                cmrs_pkg::PLLCFG_OFS: hrdata <= {12'h000, refd_q, 2'h0, loop_q, 3'h0, post_q};
                cmrs_pkg::STAT_OFS: hrdata <= {28'h0000000, oscchg_q, lockchg_q, oscup_q, lock_q};
                cmrs_pkg::SRC_OFS: hrdata <= {29'h00000000, src_q};
                default: hrdata <= 32'h0000_0000;
            endcase
        end
    end

    // Checks
    // Pin drive ends at count limit
    pin_release_a: assert property (@(posedge hclk) disable iff (!hresetn)
        seq_q && cnt_q >= 10'(PIN_LOW) |-> !reset_pin_oe) else $error("pin still driven");
    pin_drive_a: assert property (@(posedge hclk) disable iff (!hresetn)
        trig |=> reset_pin_oe) else $error("pin not driven");
    seq_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
        seq_q && cnt_q < 10'(SEQ_LEN) |=> !sys_reset_n) else $error("reset released early");
    pin_extend_a: assert property (@(posedge hclk) disable iff (!hresetn)
        seq_q && !reset_pin_in |=> seq_q) else $error("reset released with pin low");
    lock_osc_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !lock_q |-> !oscup_q) else $error("osc up without lock");
    div_four_a: assert property (@(posedge hclk) disable iff (!hresetn)
        osc_en && !oscup_q |-> force_div4) else $error("no div4");
    sel_force_a: assert property (@(posedge hclk) disable iff (!hresetn)
        $fell(oscup_q) |=> pll_clock_select) else $error("select not forced");
    fstop_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
        full_stop |-> !osc_enable && !pll_enable) else $error("full stop not off");
    rst_freq_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !sys_reset_n |-> pll_at_reset_freq) else $error("reset freq missing");
    // Mode, monitor and sequence checks
    pin_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
        seq_q && cnt_q < 10'(PIN_LOW) |-> reset_pin_oe)
        else $error("pin not held low");

    cnt_bound_a: assert property (@(posedge hclk) disable iff (!hresetn)
        cnt_q <= 10'(SEQ_LEN))
        else $error("count past end");

    sys_seq_a: assert property (@(posedge hclk) disable iff (!hresetn)
        sys_reset_n == !seq_q)
        else $error("reset not tied to sequence");

    pin_level_a: assert property (@(posedge hclk) disable iff (!hresetn)
        reset_pin_out == 1'b0)
        else $error("pin driven high");

    src_record_a: assert property (@(posedge hclk) disable iff (!hresetn)
        trig |=> src_q == $past(trig_src))
        else $error("source not recorded");

    osc_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
        mon_osc |-> osc_en && osc_monitor_reset_enable)
        else $error("osc monitor ungated");

    wdog_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
        trig_src == cmrs_pkg::SRC_WDOG |-> ctrl_q[cmrs_pkg::CTRL_WDPER_LSB +: 3] != 3'h0)
        else $error("watchdog ungated");

    osc_monitor_reset_enable_frozen_a: assert property (@(posedge hclk) disable iff (!hresetn)
        osc_en |=> $stable(osc_monitor_reset_enable))
        else $error("monitor enable changed");

    osc_mon_a: assert property (@(posedge hclk) disable iff (!hresetn)
        mon_osc && !seq_q |=> seq_q)
        else $error("osc monitor ignored");

    pll_mon_a: assert property (@(posedge hclk) disable iff (!hresetn)
        mon_pll && !seq_q |=> seq_q)
        else $error("pll monitor ignored");

    fstop_mon_a: assert property (@(posedge hclk) disable iff (!hresetn)
        full_stop |-> !mon_osc && !mon_pll)
        else $error("monitor active in full stop");

    pll_run_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !full_stop |-> pll_enable)
        else $error("pll off outside full stop");

    int_mode_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !osc_en |-> clock_mode == 2'h0 && !use_osc_ref)
        else $error("not internal mode");

    ext_ref_a: assert property (@(posedge hclk) disable iff (!hresetn)
        osc_en |-> use_osc_ref)
        else $error("oscillator reference missing");

    lock_div_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !lock_q |-> force_div4)
        else $error("no div4 unlocked");

    wdog_src_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !osc_en |-> wdog_clock_sel != 2'h2)
        else $error("osc watchdog clock while off");

    aux_stop_a: assert property (@(posedge hclk) disable iff (!hresetn)
        aux_clock_stop_disable |-> stop)
        else $error("aux stop outside stop");

    cov_hold_c: cover property (@(posedge hclk) disable iff (!hresetn)
        seq_q && cnt_q == 10'(SEQ_LEN) && !reset_pin_in);
    cov_oscmon_c: cover property (@(posedge hclk) disable iff (!hresetn) trig && mon_osc);
    cov_seq_c: cover property (@(posedge hclk) disable iff (!hresetn) $rose(seq_q));
    cov_bypass_c: cover property (@(posedge hclk) disable iff (!hresetn)
        clock_mode == 2'(cmrs_pkg::CMRS_BYPASS_TYPE_PBE));
    cov_fall_c: cover property (@(posedge hclk) disable iff (!hresetn) $fell(oscup_q));
endmodule

// [test/cmrs_osc_pin_model.sv]
`timescale 1ns/100ps
module cmrs_osc_pin_model #(
    parameter int STARTUP = 4
) (
    input wire logic hclk,
    input wire logic osc_enable,
    input wire logic reset_pin_oe,
    input wire logic reset_pin_out,
    input wire logic hold_low,
    input wire logic osc_fail,
    output logic osc_good,
    output logic osc_freq_ok,
    output logic reset_pin_in
);
    int cnt_q = 0;
    always @(posedge hclk) begin
        if (!osc_enable || osc_fail) begin
            cnt_q <= 0;
        end else if (cnt_q < STARTUP) begin
            cnt_q <= cnt_q + 1;
        end
    end
    assign osc_good = (cnt_q == STARTUP);
    assign osc_freq_ok = osc_good;
    assign reset_pin_in = !(reset_pin_oe && !reset_pin_out) && !hold_low;
endmodule

// [test/tb.sv]
`timescale 1ns/100ps
module tb;
    localparam int PL = 8;
    localparam int SL = 12;
    logic hclk, hresetn, hsel, hwrite, rdp, pll_tick, pll_locked, pll_freq_ok;
    logic por_event, lvr_event, wdog_event, hold_low, osc_fail, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans, wdog_clock_sel, clock_mode;
    logic osc_good, osc_freq_ok, reset_pin_in, reset_pin_out, reset_pin_oe;
    logic sys_reset_n, osc_enable, pll_enable, pll_clock_select, use_osc_ref;
    logic pll_at_reset_freq, force_div4;
    logic [31:0] exp_q[$];
    logic [2:0] srcs[3] = '{cmrs_pkg::SRC_POR, cmrs_pkg::SRC_LVR, cmrs_pkg::SRC_PLLMON};
    int num_errors = 0;
    int n_compared = 0;
    int r;
    cmrs_sequencer #(.PIN_LOW(PL), .SEQ_LEN(SL)) dut (.*, .hsize(3'h2), .hready(hreadyout),
        .post_divider(), .loop_multiplier(), .ref_divider(), .lock_irq_enable(),
        .osc_status_irq_enable(), .aux_clock_stop_disable());
    cmrs_osc_pin_model m (.*);
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    task automatic cmp_bit(string nm, logic e, logic g);
        n_compared++;
        if (g !== e) begin
            num_errors++;
            $display("wrong value %s expected %b seen %b", nm, e, g);
        end
    endtask
    task automatic cmp_word(string nm, logic [31:0] e, logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        rdp <= !w;
        if (!w) exp_q.push_back(d);
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rdp <= 1'b0;
    endtask
    task automatic step(int k);
        repeat (k) @(posedge hclk);
    endtask
    task automatic wosc();
        int n;
        n = 0;
        while (osc_good !== 1'b1 && n < 50) begin
            @(posedge hclk);
            n++;
        end
    endtask
    task automatic seq(logic [2:0] src);
        int n;
        int p;
        n = 0;
        p = 0;
        while (reset_pin_oe !== 1'b1 && n < 20) begin
            @(posedge hclk);
            n++;
        end
        cmp_bit("reset_freq", 1'b1, pll_at_reset_freq);
        n = 0;
        while (sys_reset_n !== 1'b1 && n < 200) begin
            if (reset_pin_oe === 1'b1) p++;
            @(posedge hclk);
            n++;
        end
        cmp_bit("pin_low_len", 1'b1, p == PL);
        cmp_bit("seq_len", 1'b1, n >= SL && n <= SL + 2);
        bus(0, cmrs_pkg::SRC_OFS, {29'h0, src});
    endtask
    task automatic wrap_up();
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial forever begin
        @(posedge hclk);
        if (rdp === 1'b1 && exp_q.size() > 0) cmp_word("hrdata", exp_q.pop_front(), hrdata);
    end
    initial begin
        step(20000);
        num_errors++;
        wrap_up();
    end
    initial begin
        {hresetn, hsel, hwrite, rdp, por_event, lvr_event, wdog_event} = '0;
        {hold_low, osc_fail, htrans, haddr, hwdata} = '0;
        {pll_tick, pll_locked, pll_freq_ok} = 3'h7;
        r = $urandom(72203);
        step(5);
        hresetn <= 1'b1;
        step(1);
        cmp_bit("pll_select", 1'b1, pll_clock_select);
        cmp_bit("mode_int", 1'b1, clock_mode === 2'h0 && use_osc_ref === 1'b0);
        bus(0, cmrs_pkg::CTRL_OFS, cmrs_pkg::CTRL_RST);
        bus(0, cmrs_pkg::PLLCFG_OFS, 32'h0000_1803);
        bus(0, 8'h10, 32'h0);
        r = $urandom % 32;
        bus(1, cmrs_pkg::PLLCFG_OFS, 32'h0000_1800 | 32'(r));
        bus(0, cmrs_pkg::PLLCFG_OFS, 32'h0000_1800 | 32'(r));
        for (int i = 0; i < 3; i++) begin
            por_event <= (i == 0);
            lvr_event <= (i == 1);
            pll_freq_ok <= (i != 2);
            step(1);
            {por_event, lvr_event, pll_freq_ok} <= 3'h1;
            seq(srcs[i]);
        end
        hold_low <= 1'b1;
        step(1);
        hold_low <= 1'b0;
        seq(cmrs_pkg::SRC_PIN);
        hold_low <= 1'b1;
        step(2 * SL);
        cmp_bit("held_reset", 1'b0, sys_reset_n);
        hold_low <= 1'b0;
        step(3);
        cmp_bit("held_release", 1'b1, sys_reset_n);
        bus(0, cmrs_pkg::SRC_OFS, {29'h0, cmrs_pkg::SRC_PIN});
        wdog_event <= 1'b1;
        step(1);
        wdog_event <= 1'b0;
        step(4);
        cmp_bit("wdog_gated", 1'b1, sys_reset_n);
        r = $urandom % 2;
        bus(1, cmrs_pkg::CTRL_OFS, 32'h0000_0101 | (32'(r) << 6));
        step(1);
        cmp_bit("wdog_sel", 1'b1, wdog_clock_sel === 2'(r));
        wdog_event <= 1'b1;
        step(1);
        wdog_event <= 1'b0;
        seq(cmrs_pkg::SRC_WDOG);
        bus(1, cmrs_pkg::CTRL_OFS, 32'h0000_0003);
        wosc();
        step(2);
        bus(1, cmrs_pkg::STAT_OFS, 32'h0000_000C);
        bus(0, cmrs_pkg::STAT_OFS, 32'h0000_0003);
        cmp_bit("mode_ext", 1'b1, clock_mode === 2'h1 && use_osc_ref === 1'b1);
        pll_locked <= 1'b0;
        step(3);
        bus(0, cmrs_pkg::STAT_OFS, 32'h0000_000C);
        cmp_bit("div4", 1'b1, force_div4);
        pll_locked <= 1'b1;
        step(3);
        bus(1, cmrs_pkg::STAT_OFS, 32'h0000_000C);
        bus(1, cmrs_pkg::CTRL_OFS, 32'h0000_0002);
        step(1);
        cmp_bit("mode_byp", 1'b1, clock_mode === 2'h2 && pll_clock_select === 1'b0);
        osc_fail <= 1'b1;
        step(4);
        cmp_bit("auto_select", 1'b1, pll_clock_select);
        cmp_bit("no_oscmon", 1'b1, sys_reset_n);
        osc_fail <= 1'b0;
        bus(1, cmrs_pkg::CTRL_OFS, 32'h0000_1803);
        step(1);
        cmp_bit("fstop", 1'b0, osc_enable | pll_enable);
        bus(1, cmrs_pkg::CTRL_OFS, 32'h0000_0005);
        bus(1, cmrs_pkg::CTRL_OFS, 32'h0000_0007);
        seq(cmrs_pkg::SRC_OSCMON);
        bus(0, cmrs_pkg::CTRL_OFS, 32'h0000_0007);
        wosc();
        osc_fail <= 1'b1;
        step(1);
        osc_fail <= 1'b0;
        seq(cmrs_pkg::SRC_OSCMON);
        wrap_up();
    end
endmodule
